/* shared/bmf_map.vh */
`ifndef BMF_MAP_VH
`define BMF_MAP_VH

// ==========================================================================
// widths of the long word, the narrow ports and one byte lane
`define BMF_LWORD_W      36
`define BMF_NARROW_W     18
`define BMF_BYTE_W       9

// ==========================================================================
// queue geometry: sixteen long words per direction
`define BMF_FIFO_DEPTH   16
`define BMF_FIFO_AW      4

// ==========================================================================
// pieces per long word on a narrow port
`define BMF_PIECES_WORD  3'd2
`define BMF_PIECES_BYTE  3'd4

// last piece index seen on the receive side
`define BMF_LAST_WORD    2'd1
`define BMF_LAST_BYTE    2'd3

// ==========================================================================
// fall-through: output stage loads on the third port clock edge
`define BMF_FALL_LAST    2'd2

// ==========================================================================
// reset values
`define BMF_RST_LEFT     3'd0
`define BMF_RST_FALL     2'd0
`define BMF_RST_RXCNT    2'd0
`define BMF_RST_LWORD    36'h000000000
`define BMF_RST_NARROW   18'h00000

`endif

/* design/bmf_fifo.v */
`timescale 1ns/1ps

// ==========================================================================
// bmf_fifo: long word queue with a registered output stage
module bmf_fifo #(
	parameter WIDTH = 36,
	parameter DEPTH = 16,
	parameter AW    = 4
)
(
	// clock and reset
	input  wire             clk_i,
	input  wire             rst_b_i,
	// filling side
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	// draining side
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);

	localparam [AW:0] FULL_CNT = DEPTH[AW:0];

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wp_q;
	reg [AW-1:0]    rp_q;
	reg [AW:0]      cnt_q;
	reg             out_valid_q;
	reg [WIDTH-1:0] out_data_q;
	wire            push;
	wire            pop_mem;

	// the output register counts as one extra slot; full refers to the array only
	assign in_ready_o  = (cnt_q != FULL_CNT);
	assign out_valid_o = out_valid_q;
	assign out_data_o  = out_data_q;
	assign push        = in_valid_i & in_ready_o;
	assign pop_mem     = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready_i);

	// array write, no reset needed on storage
	always @(posedge clk_i)
	begin
		if (push)
			mem_q[wp_q] <= in_data_i;
	end

	// pointers, fill count and output stage
	always @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			wp_q        <= {AW{1'b0}};
			rp_q        <= {AW{1'b0}};
			cnt_q       <= {(AW+1){1'b0}};
			out_valid_q <= 1'b0;
			out_data_q  <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop_mem)
			begin
				out_data_q  <= mem_q[rp_q];   // read data always leave a register
				rp_q        <= rp_q + 1'b1;
				out_valid_q <= 1'b1;
			end
			else if (out_ready_i)
				out_valid_q <= 1'b0;
			if (push & ~pop_mem)
				cnt_q <= cnt_q + 1'b1;
			else if (~push & pop_mem)
				cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule

/* design/bmf_ports.v */
`timescale 1ns/1ps
`include "bmf_map.vh"

// Functional notes
// RULE_01 - receive word mode: two words build a long word, order set by endianness
// RULE_02 - receive byte mode: four bytes on low lines build a long word
// RULE_03 - transmit word mode: long word leaves as two halves, endian ordered
// RULE_04 - transmit byte mode: four bytes on low lines, endian ordered
// RULE_05 - endianness is captured at reset and held until the next reset
// RULE_06 - outside party keeps both size selects static during operation
// RULE_07 - upper transmit lines carry no meaning in byte mode
// RULE_08 - fall-through: ready and first data on transmit within three clock edges
// RULE_09 - fall-through: transmit ready drops on reading the last held piece
// RULE_10 - standard: transmit empty flag deasserts on the next transmit clock edge
// RULE_11 - standard: transmit empty flag asserts on reading the last piece
// RULE_12 - fall-through: wide ready and data within three wide clock edges
// RULE_13 - receive-side delay counts from the edge writing the final piece
// RULE_14 - standard: wide empty flag deasserts on the next wide clock edge
// RULE_15 - partial long words wait in a register, final piece commits all
// RULE_16 - queue read a long word at a time, remainder kept for later reads
// RULE_17 - each port clock is its own domain, flags follow synchronised state
module bmf_ports
(
	// system clock and reset
	input  wire        clk_i,
	input  wire        rst_b_i,
	// configuration straps
	input  wire        endian_sel_i,
	input  wire        fall_through_mode_i,
	input  wire        transmit_port_size_sel_i,
	input  wire        receive_port_size_sel_i,
	// wide two-way port
	input  wire        wide_port_clock_i,
	input  wire        wide_wr_en_i,
	input  wire        wide_rd_en_i,
	input  wire [35:0] wide_data_i,
	output wire [35:0] wide_data_o,
	output wire        wide_data_oe_o,
	output wire        wide_empty_n_o,
	output wire        wide_output_ready_o,
	output wire        wide_input_ready_o,
	// transmit port
	input  wire        transmit_port_clock_i,
	input  wire        transmit_rd_en_i,
	output wire [17:0] transmit_data_o,
	output wire        transmit_empty_n_o,
	output wire        transmit_output_ready_o,
	// receive port
	input  wire        receive_port_clock_i,
	input  wire        receive_wr_en_i,
	input  wire [17:0] receive_data_i,
	output wire        receive_input_ready_o
);

	// ======================================================================
	// helpers

	// slot of a byte, counted from the top lane, for a given arrival index
	function [1:0] byte_slot;
		input [1:0] idx;
		input       big;
		begin
			byte_slot = big ? idx : (2'd3 - idx);
		end
	endfunction

	// narrow piece number idx of a long word for the transmit side
	function [17:0] tx_piece;
		input [35:0] lw;
		input [2:0]  idx;
		input        byte_mode;
		input        big;
		reg   [1:0]  slot;
		begin
			slot = byte_slot(idx[1:0], big);
			if (byte_mode)
				tx_piece = {9'h000, lw[35-9*slot -: 9]};   // upper lines zero [RULE_07] [RULE_04]
			else if (idx[0] ^ ~big)
				tx_piece = lw[17:0];                       // [RULE_03]
			else
				tx_piece = lw[35:18];
		end
	endfunction

	// ======================================================================
	// synchronisers: every pin but clk_i and rst_b_i passes two flops before use

	reg        w_clk_s1, w_clk_s2, w_clk_s3;
	reg        t_clk_s1, t_clk_s2, t_clk_s3;
	reg        r_clk_s1, r_clk_s2, r_clk_s3;
	reg        w_wr_s1, w_wr_s2, w_rd_s1, w_rd_s2;
	reg        t_rd_s1, t_rd_s2, r_wr_s1, r_wr_s2;
	reg [35:0] w_dat_s1, w_dat_s2;
	reg [17:0] r_dat_s1, r_dat_s2;
	reg        end_s1, end_s2, ft_s1, ft_s2;
	reg        tsz_s1, tsz_s2, rsz_s1, rsz_s2;

	// data and enables ride the same depth as the clocks so they stay aligned
	always @(posedge clk_i)
	begin
		w_clk_s1 <= wide_port_clock_i;
		w_clk_s2 <= w_clk_s1;
		w_clk_s3 <= w_clk_s2;
		t_clk_s1 <= transmit_port_clock_i;
		t_clk_s2 <= t_clk_s1;
		t_clk_s3 <= t_clk_s2;
		r_clk_s1 <= receive_port_clock_i;
		r_clk_s2 <= r_clk_s1;
		r_clk_s3 <= r_clk_s2;
		w_wr_s1  <= wide_wr_en_i;
		w_wr_s2  <= w_wr_s1;
		w_rd_s1  <= wide_rd_en_i;
		w_rd_s2  <= w_rd_s1;
		t_rd_s1  <= transmit_rd_en_i;
		t_rd_s2  <= t_rd_s1;
		r_wr_s1  <= receive_wr_en_i;
		r_wr_s2  <= r_wr_s1;
		w_dat_s1 <= wide_data_i;
		w_dat_s2 <= w_dat_s1;
		r_dat_s1 <= receive_data_i;
		r_dat_s2 <= r_dat_s1;
		end_s1   <= endian_sel_i;
		end_s2   <= end_s1;
		ft_s1    <= fall_through_mode_i;
		ft_s2    <= ft_s1;
		tsz_s1   <= transmit_port_size_sel_i;
		tsz_s2   <= tsz_s1;
		rsz_s1   <= receive_port_size_sel_i;
		rsz_s2   <= rsz_s1;
	end

	// rising edges of each port clock, one system cycle wide
	wire w_edge = w_clk_s2 & ~w_clk_s3;   // [RULE_17]
	wire t_edge = t_clk_s2 & ~t_clk_s3;   // [RULE_17]
	wire r_edge = r_clk_s2 & ~r_clk_s3;   // [RULE_17]

	// ======================================================================
	// configuration caught while reset is held

	reg big_q, fall_through_mode_q, tbyte_q, rbyte_q;

	// sizes are latched too: they are required static, so nothing is lost
	always @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			big_q   <= end_s2;     // [RULE_05]
			fall_through_mode_q  <= ft_s2;
			tbyte_q <= tsz_s2;     // [RULE_06]
			rbyte_q <= rsz_s2;     // [RULE_06]
		end
	end

	// ======================================================================
	// queues

	wire        q1_in_valid, q1_in_ready, q1_out_valid, q1_out_ready;
	wire [35:0] q1_out_data;
	wire        q2_in_valid, q2_in_ready, q2_out_valid, q2_out_ready;
	wire [35:0] q2_out_data;
	reg  [35:0] rx_acc_q;
	reg  [35:0] rx_word;

	bmf_fifo #(
		.WIDTH (`BMF_LWORD_W),
		.DEPTH (`BMF_FIFO_DEPTH),
		.AW    (`BMF_FIFO_AW)
	) u_wide_to_transmit_queue (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (q1_in_valid),
		.in_ready_o  (q1_in_ready),
		.in_data_i   (w_dat_s2),
		.out_valid_o (q1_out_valid),
		.out_ready_i (q1_out_ready),
		.out_data_o  (q1_out_data)
	);

	bmf_fifo #(
		.WIDTH (`BMF_LWORD_W),
		.DEPTH (`BMF_FIFO_DEPTH),
		.AW    (`BMF_FIFO_AW)
	) u_receive_to_wide_queue (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (q2_in_valid),
		.in_ready_o  (q2_in_ready),
		.in_data_i   (rx_word),
		.out_valid_o (q2_out_valid),
		.out_ready_i (q2_out_ready),
		.out_data_o  (q2_out_data)
	);

	// wide writes are refused while the queue is full
	assign q1_in_valid = w_edge & w_wr_s2 & q1_in_ready;

	// ======================================================================
	// receive side: assemble narrow pieces into a long word

	reg  [1:0] rx_cnt_q;
	wire       rx_wr    = r_edge & r_wr_s2 & q2_in_ready;
	wire [1:0] rx_last  = rbyte_q ? `BMF_LAST_BYTE : `BMF_LAST_WORD;
	wire       rx_final = rx_wr & (rx_cnt_q == rx_last);
	reg  [1:0] rx_slot;

	// place the incoming piece into the partial long word
	always @*
	begin
		rx_word = rx_acc_q;
		rx_slot = byte_slot(rx_cnt_q, big_q);
		if (rbyte_q)
			rx_word[35-9*rx_slot -: 9] = r_dat_s2[8:0];   // [RULE_02]
		else if (rx_cnt_q[0] ^ ~big_q)
			rx_word[17:0] = r_dat_s2;                     // [RULE_01]
		else
			rx_word[35:18] = r_dat_s2;                    // [RULE_01]
	end

	// whole long word enters the queue on the edge of the final piece
	assign q2_in_valid = rx_final;   // [RULE_15] [RULE_13]

	always @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			rx_cnt_q <= `BMF_RST_RXCNT;
			rx_acc_q <= `BMF_RST_LWORD;
		end
		else if (rx_wr)
		begin
			rx_acc_q <= rx_final ? `BMF_RST_LWORD : rx_word;   // [RULE_15]
			rx_cnt_q <= rx_final ? `BMF_RST_RXCNT : rx_cnt_q + 2'd1;
		end
	end

	// ======================================================================
	// transmit side: hold one long word, hand it out piece by piece

	reg  [35:0] tx_hold_q;
	reg  [2:0]  tx_left_q;
	reg  [2:0]  tx_left_d;
	reg  [1:0]  tx_fall_q;
	reg  [17:0] tx_dat_q;
	reg         tx_empty_n_q;
	reg         tx_ready_q;
	wire [2:0]  tx_n    = tbyte_q ? `BMF_PIECES_BYTE : `BMF_PIECES_WORD;
	wire        tx_read = t_edge & t_rd_s2 & (tx_left_q != 3'd0);
	wire        tx_last = tx_read & (tx_left_q == 3'd1);
	wire        tx_free = (tx_left_q == 3'd0) | tx_last;
	// standard mode loads at once; fall-through loads on the third edge when idle
	wire        tx_load = t_edge & tx_free & q1_out_valid &
		(~fall_through_mode_q | tx_last | (tx_fall_q == `BMF_FALL_LAST));

	assign q1_out_ready = tx_load;   // [RULE_16]

	// pieces still held after this cycle
	always @*
	begin
		tx_left_d = tx_left_q;
		if (tx_load)
			tx_left_d = tx_n;
		else if (tx_read)
			tx_left_d = tx_left_q - 3'd1;
	end

	always @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			tx_hold_q    <= `BMF_RST_LWORD;
			tx_left_q    <= `BMF_RST_LEFT;
			tx_fall_q    <= `BMF_RST_FALL;
			tx_dat_q     <= `BMF_RST_NARROW;
			tx_empty_n_q <= 1'b0;
			tx_ready_q   <= 1'b0;
		end
		else
		begin
			tx_left_q    <= tx_left_d;
			tx_empty_n_q <= ~fall_through_mode_q & (tx_left_d != 3'd0);   // [RULE_10] [RULE_11]
			tx_ready_q   <= fall_through_mode_q & (tx_left_d != 3'd0);    // [RULE_08] [RULE_09]
			if (tx_load)
				tx_hold_q <= q1_out_data;                    // [RULE_16]
			// fall-through delay counter, only while idle with data waiting
			if (tx_load | ~q1_out_valid | (tx_left_q != 3'd0))
				tx_fall_q <= `BMF_RST_FALL;
			else if (t_edge & fall_through_mode_q)
				tx_fall_q <= tx_fall_q + 2'd1;               // [RULE_08]
			// output register: standard shows a piece on the read itself,
			// fall-through shows it ahead of the read
			if (fall_through_mode_q)
			begin
				if (tx_load)
					tx_dat_q <= tx_piece(q1_out_data, 3'd0, tbyte_q, big_q);
				else if (tx_read)
					tx_dat_q <= tx_piece(tx_hold_q, tx_n - tx_left_q + 3'd1,
						tbyte_q, big_q);
			end
			else if (tx_read)
				tx_dat_q <= tx_piece(tx_hold_q, tx_n - tx_left_q, tbyte_q, big_q);
		end
	end

	// ======================================================================
	// wide read side: one long word per read

	reg        wr_held_q;
	reg [1:0]  wr_fall_q;
	reg [35:0] wr_hold_q;
	reg [35:0] wr_dat_q;
	reg        wr_empty_n_q;
	reg        wr_ready_q;
	reg        wr_oe_q;
	reg        w_in_ready_q;
	reg        r_in_ready_q;
	reg        wr_held_d;
	wire       wr_read = w_edge & w_rd_s2 & wr_held_q;
	wire       wr_free = ~wr_held_q | wr_read;
	wire       wr_load = w_edge & wr_free & q2_out_valid &
		(~fall_through_mode_q | wr_read | (wr_fall_q == `BMF_FALL_LAST));

	assign q2_out_ready = wr_load;

	always @*
	begin
		wr_held_d = wr_held_q;
		if (wr_load)
			wr_held_d = 1'b1;
		else if (wr_read)
			wr_held_d = 1'b0;
	end

	always @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			wr_held_q    <= 1'b0;
			wr_fall_q    <= `BMF_RST_FALL;
			wr_hold_q    <= `BMF_RST_LWORD;
			wr_dat_q     <= `BMF_RST_LWORD;
			wr_empty_n_q <= 1'b0;
			wr_ready_q   <= 1'b0;
			wr_oe_q      <= 1'b0;
			w_in_ready_q <= 1'b0;
			r_in_ready_q <= 1'b0;
		end
		else
		begin
			wr_held_q    <= wr_held_d;
			wr_empty_n_q <= ~fall_through_mode_q & wr_held_d;   // [RULE_14]
			wr_ready_q   <= fall_through_mode_q & wr_held_d;    // [RULE_12]
			wr_oe_q      <= w_rd_s2;
			w_in_ready_q <= q1_in_ready;
			r_in_ready_q <= q2_in_ready;
			if (wr_load)
				wr_hold_q <= q2_out_data;
			// the count starts once the completed long word is visible
			if (wr_load | ~q2_out_valid | wr_held_q)
				wr_fall_q <= `BMF_RST_FALL;
			else if (w_edge & fall_through_mode_q)
				wr_fall_q <= wr_fall_q + 2'd1;     // [RULE_12] [RULE_13]
			if (fall_through_mode_q)
			begin
				if (wr_load)
					wr_dat_q <= q2_out_data;
			end
			else if (wr_read)
				wr_dat_q <= wr_hold_q;
		end
	end

	// ======================================================================
	// outputs, all straight from flops

	assign wide_data_o             = wr_dat_q;
	assign wide_data_oe_o          = wr_oe_q;
	assign wide_empty_n_o          = wr_empty_n_q;
	assign wide_output_ready_o     = wr_ready_q;
	assign wide_input_ready_o      = w_in_ready_q;
	assign transmit_data_o         = tx_dat_q;
	assign transmit_empty_n_o      = tx_empty_n_q;
	assign transmit_output_ready_o = tx_ready_q;
	assign receive_input_ready_o   = r_in_ready_q;

endmodule

/* verification/bmf_chk_chk.sv */
`timescale 1ns/1ps

// ==========================================================================
// bmf_chk: flag and data timing seen at the port pins
module bmf_chk
(
	// clock and reset
	input wire        clk_i,
	input wire        rst_b_i,
	// straps
	input wire        fall_through_mode_i,
	input wire        transmit_port_size_sel_i,
	// wide port
	input wire        wide_port_clock_i,
	input wire        wide_rd_en_i,
	input wire [35:0] wide_data_o,
	input wire        wide_data_oe_o,
	input wire        wide_empty_n_o,
	input wire        wide_output_ready_o,
	// transmit port
	input wire        transmit_port_clock_i,
	input wire        transmit_rd_en_i,
	input wire [17:0] transmit_data_o,
	input wire        transmit_empty_n_o,
	input wire        transmit_output_ready_o
);
	reg       fw_q;
	reg       bm_q;
	reg       tp_q;
	reg       wp_q;
	reg [3:0] tx_age_q;
	reg [3:0] tr_age_q;
	reg [3:0] wr_age_q;
	reg [3:0] wd_age_q;
	wire      tx_edge = transmit_port_clock_i && !tp_q;
	wire      wd_edge = wide_port_clock_i && !wp_q;
	wire      tx_flag = transmit_empty_n_o || transmit_output_ready_o;
	wire      wd_flag = wide_empty_n_o || wide_output_ready_o;

	function [3:0] age_step(input [3:0] a, input ev);
		age_step = ev ? 4'h0 : ((a == 4'hf) ? a : a + 4'h1);
	endfunction

	// ages saturate so an old event never wraps round into a fresh one
	always @(posedge clk_i)
	begin
		tp_q <= transmit_port_clock_i;
		wp_q <= wide_port_clock_i;
		if (!rst_b_i)
		begin
			fw_q     <= fall_through_mode_i;
			bm_q     <= transmit_port_size_sel_i;
			tx_age_q <= 4'hf;
			tr_age_q <= 4'hf;
			wr_age_q <= 4'hf;
			wd_age_q <= 4'hf;
		end
		else
		begin
			tx_age_q <= age_step(tx_age_q, tx_edge);
			tr_age_q <= age_step(tr_age_q, tx_edge && transmit_rd_en_i);
			wr_age_q <= age_step(wr_age_q, wd_edge && wide_rd_en_i);
			wd_age_q <= age_step(wd_age_q, wd_edge);
		end
	end

	// ==========================================================================
	// properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_rd_start;
		$rose(wide_rd_en_i);
	endsequence

	a_quiet_after_reset: assert property ($rose(rst_b_i) |-> !(tx_flag || wd_flag))
		else $error("flag high at first edge after reset");
	a_tx_mode_flag: assert property (fw_q ? !transmit_empty_n_o : !transmit_output_ready_o)
		else $error("transmit flag of the wrong mode active");
	a_wide_mode_flag: assert property (fw_q ? !wide_empty_n_o : !wide_output_ready_o)
		else $error("wide flag of the wrong mode active");
	a_byte_upper_zero: assert property (bm_q |-> transmit_data_o[17:9] == 9'h000)
		else $error("upper transmit lines driven in byte mode");
	a_tx_rise_edge: assert property ($rose(tx_flag) |-> tx_age_q inside {[1:6]})
		else $error("transmit flag rose away from a transmit clock edge");
	a_tx_fall_read: assert property ($fell(tx_flag) |-> tr_age_q inside {[1:6]})
		else $error("transmit flag fell without a read");
	a_tx_data_cause: assert property ($changed(transmit_data_o) |->
		(tr_age_q inside {[1:6]}) || $rose(transmit_output_ready_o))
		else $error("transmit data moved without read or load");
	a_wide_rise_edge: assert property ($rose(wd_flag) |-> wd_age_q inside {[1:6]})
		else $error("wide flag rose away from a wide clock edge");
	a_wide_fall_read: assert property ($fell(wd_flag) |-> wr_age_q inside {[1:6]})
		else $error("wide flag fell without a read");
	a_wide_data_cause: assert property ($changed(wide_data_o) |->
		(wr_age_q inside {[1:6]}) || $rose(wide_output_ready_o))
		else $error("wide data moved without read or load");
	a_oe_follows_read: assert property (s_rd_start |-> ##[2:4] wide_data_oe_o)
		else $error("wide drive enable did not follow read enable");
endmodule

bind bmf_ports bmf_chk i_chk
(
	.clk_i(clk_i), .rst_b_i(rst_b_i), .fall_through_mode_i(fall_through_mode_i),
	.transmit_port_size_sel_i(transmit_port_size_sel_i), .wide_port_clock_i(wide_port_clock_i),
	.wide_rd_en_i(wide_rd_en_i), .wide_data_o(wide_data_o), .wide_data_oe_o(wide_data_oe_o),
	.wide_empty_n_o(wide_empty_n_o), .wide_output_ready_o(wide_output_ready_o),
	.transmit_port_clock_i(transmit_port_clock_i), .transmit_rd_en_i(transmit_rd_en_i),
	.transmit_data_o(transmit_data_o), .transmit_empty_n_o(transmit_empty_n_o),
	.transmit_output_ready_o(transmit_output_ready_o)
);

/* verification/bmf_peer.sv */
`timescale 1ns/1ps

// ==========================================================================
// bmf_peer: synchronous processor on one port, free-running port clock
module bmf_peer #(
	parameter int PH = 130
)
(
	// block clock, used to place changes just after its edge
	input  wire         clk_i,
	// port side
	output logic        pclk_o,
	output logic [1:0]  en_o,
	output logic [35:0] dat_o
);
	// port clock runs between transfers too
	initial
	begin
		pclk_o = 1'b0;
		en_o   = 2'b00;
		dat_o  = 36'h0;
		#(PH);
		forever #400 pclk_o = ~pclk_o;
	end

	// one transfer: set up half a period ahead, hold half a period after
	task automatic xfer(input logic [1:0] e, input logic [35:0] d);
		@(negedge pclk_o);
		@(posedge clk_i);
		#2;
		en_o  = e;
		dat_o = d;
		@(posedge pclk_o);
		@(negedge pclk_o);
		@(posedge clk_i);
		#2;
		en_o  = 2'b00;
		dat_o = ~d; // released lines no longer show the old value
	endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps

// ==========================================================================
// tb_top: all four size and endian modes, both queue directions
module tb_top;
	logic        clk_i;
	logic        rst_b_i;
	logic        endian_sel_i;
	logic        fall_through_mode_i;
	logic        size_sel;
	int          n_fail;
	int          check_count;
	wire         wclk, tclk, rclk;
	wire [1:0]   wen, ten, ren;
	wire [35:0]  wdat, rdat, wide_data_o;
	wire [17:0]  transmit_data_o;
	wire         wide_data_oe_o, wide_empty_n_o, wide_output_ready_o, wide_input_ready_o;
	wire         transmit_empty_n_o, transmit_output_ready_o, receive_input_ready_o;
	wire         tx_flag = fall_through_mode_i ? transmit_output_ready_o : transmit_empty_n_o;
	wire         wd_flag = fall_through_mode_i ? wide_output_ready_o : wide_empty_n_o;
	wire [17:0]  tx_got = size_sel ? {9'h000, transmit_data_o[8:0]} : transmit_data_o;

	bmf_peer #(.PH(130)) i_wide (.clk_i(clk_i), .pclk_o(wclk), .en_o(wen), .dat_o(wdat));
	bmf_peer #(.PH(270)) i_tx (.clk_i(clk_i), .pclk_o(tclk), .en_o(ten), .dat_o());
	bmf_peer #(.PH(490)) i_rx (.clk_i(clk_i), .pclk_o(rclk), .en_o(ren), .dat_o(rdat));

	bmf_ports i_dut
	(
		.clk_i(clk_i), .rst_b_i(rst_b_i), .endian_sel_i(endian_sel_i),
		.fall_through_mode_i(fall_through_mode_i), .transmit_port_size_sel_i(size_sel),
		.receive_port_size_sel_i(size_sel), .wide_port_clock_i(wclk), .wide_wr_en_i(wen[0]),
		.wide_rd_en_i(wen[1]), .wide_data_i(wdat), .wide_data_o(wide_data_o),
		.wide_data_oe_o(wide_data_oe_o), .wide_empty_n_o(wide_empty_n_o),
		.wide_output_ready_o(wide_output_ready_o), .wide_input_ready_o(wide_input_ready_o),
		.transmit_port_clock_i(tclk), .transmit_rd_en_i(ten[0]), .transmit_data_o(transmit_data_o),
		.transmit_empty_n_o(transmit_empty_n_o), .transmit_output_ready_o(transmit_output_ready_o),
		.receive_port_clock_i(rclk), .receive_wr_en_i(ren[0]), .receive_data_i(rdat[17:0]),
		.receive_input_ready_o(receive_input_ready_o)
	);

	// 10 MHz block clock
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ==========================================================================
	// expectations and checks
	function automatic [35:0] lw_of(input int w);
		lw_of = 36'h9a5c3e172 + 36'h123456789 * w;
	endfunction

	// piece k of a long word in port order; j counts lanes from the top
	function automatic [17:0] piece(input [35:0] lw, input int k, input bit bm, input bit big);
		int j;
		j = big ? k : (bm ? 3 - k : 1 - k);
		piece = bm ? {9'h000, lw[35 - 9 * j -: 9]} : ((j == 0) ? lw[35:18] : lw[17:0]);
	endfunction

	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic wait_flag(input bit wide, input int lim);
		int n;
		n = 0;
		while ((wide ? wd_flag : tx_flag) !== 1'b1 && n < lim)
		begin
			@(posedge clk_i);
			#2;
			n++;
		end
		check_count++;
		if ((wide ? wd_flag : tx_flag) !== 1'b1)
		begin
			n_fail++;
			$display("unexpected flag %0d: expected 1, seen 0 after %0d cycles", wide, lim);
			conclude();
		end
	endtask

	task automatic settle;
		repeat (3) @(posedge clk_i);
		#2;
	endtask

	task automatic conclude;
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================================
	// one configuration: standard mode overfills the queue, fall-through sends two
	// standard holds 18 long words: 16 in the array, the queue output stage, the hold
	task automatic run_cfg(input int c);
		bit          big;
		bit          bm;
		bit          fw;
		int          nw;
		int          np;
		logic [35:0] lw;
		logic [17:0] p;
		big = c[0];
		bm  = c[1];
		fw  = c[0] ^ c[1];
		nw  = fw ? 2 : 19;
		np  = bm ? 4 : 2;
		@(posedge clk_i);
		#2;
		rst_b_i             = 1'b0;
		endian_sel_i        = big;
		fall_through_mode_i = fw;
		size_sel            = bm;
		repeat (6) @(posedge clk_i);
		#2;
		rst_b_i = 1'b1;
		@(posedge clk_i);
		#2;
		endian_sel_i = ~big;
		for (int w = 0; w < nw; w++)
			i_wide.xfer(2'b01, lw_of(w));
		chk("wide input ready", fw ? 36'h1 : 36'h0, wide_input_ready_o);
		wait_flag(1'b0, fw ? 40 : 24);
		for (int w = 0; w < (fw ? nw : 18); w++)
			for (int k = 0; k < np; k++)
			begin
				chk("transmit flag", 36'h1, tx_flag);
				if (fw)
					chk("transmit data", piece(lw_of(w), k, bm, big), tx_got);
				i_tx.xfer(2'b01, 36'h0);
				settle();
				if (!fw)
					chk("transmit data", piece(lw_of(w), k, bm, big), tx_got);
			end
		chk("transmit flag", 36'h0, tx_flag);
		lw = lw_of(c + 5);
		for (int k = 0; k < np; k++)
		begin
			p = piece(lw, k, bm, big);
			i_rx.xfer(2'b01, {18'h0, bm ? {9'h1b6, p[8:0]} : p});
			if (k < np - 1)
			begin
				repeat (32) @(posedge clk_i);
				chk("wide flag early", 36'h0, wd_flag);
			end
		end
		chk("receive input ready", 36'h1, receive_input_ready_o);
		wait_flag(1'b1, fw ? 40 : 24);
		if (fw)
			chk("wide data", lw, wide_data_o);
		i_wide.xfer(2'b10, 36'h0);
		settle();
		if (!fw)
			chk("wide data", lw, wide_data_o);
		chk("wide flag", 36'h0, wd_flag);
		$display("config %0d done", c);
	endtask

	initial
	begin
		rst_b_i             = 1'b0;
		endian_sel_i        = 1'b0;
		fall_through_mode_i = 1'b0;
		size_sel            = 1'b0;
		n_fail              = 0;
		check_count         = 0;
		for (int c = 0; c < 4; c++)
			run_cfg(c);
		conclude();
	end
endmodule
